// ### ips_pkg.sv
// Package with constants and types for the inter-switch port frame steering block.
package ips_pkg;

  // Link control facility address for switch-side ports.
  localparam logic [23:0] IPS_LCF_ADDR = 24'hfffffd;
  // Word kinds presented by the link decoder.
  typedef enum logic [2:0] {
    IPS_W_IDLE, IPS_W_PSIG, IPS_W_PSEQ, IPS_W_SOF, IPS_W_DATA, IPS_W_EOF
  } ips_word_e;
  // Service classes carried by the start delimiter.
  localparam logic [1:0] IPS_CLS_F = 2'h0;
  localparam logic [1:0] IPS_CLS_2 = 2'h2;
  localparam logic [1:0] IPS_CLS_3 = 2'h3;
  // Data field limit before parameter exchange, in bytes and in 32-bit words.
  localparam int IPS_PRE_ELP_BYTES = 256;
  localparam logic [9:0] IPS_PRE_ELP_WORDS = 10'(IPS_PRE_ELP_BYTES / 4);
  // Header words before the data field begins; the first one carries the destination.
  localparam logic [9:0] IPS_HDR_WORDS = 10'h006;
  // Credit assumed toward the peer before parameter exchange.
  localparam logic [7:0] IPS_PRE_ELP_CREDIT = 8'h01;
  // Value of the credit counters after reset.
  localparam logic [7:0] IPS_CREDIT_RST = 8'h00;
  // Frame destinations.
  typedef enum logic [1:0] {IPS_DST_NONE, IPS_DST_MAIN, IPS_DST_CTRL} ips_dst_e;

endpackage

// ### ips_credit.sv
`timescale 1ns/1ps
// Buffer-to-buffer credit counter for frames sent toward the peer.
module ips_credit
  import ips_pkg::*;
#(
  parameter int CW = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic paramDone,
  input wire logic [CW-1:0] agreedCredit,
  input wire logic frameSent,
  input wire logic readyRcvd,
  output logic canSend
);

  logic [CW-1:0] used_q, used_d;
  logic [CW-1:0] limit;

  // Until parameters are exchanged only one frame may be outstanding.
  always_comb begin
    limit = paramDone ? agreedCredit : CW'(IPS_PRE_ELP_CREDIT);
    used_d = used_q;
    if (frameSent && !readyRcvd) begin
      used_d = used_q + CW'(1);
    end else if (!frameSent && readyRcvd && used_q != '0) begin
      used_d = used_q - CW'(1);
    end
  end

  // Counter register.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      used_q <= CW'(IPS_CREDIT_RST);
    end else begin
      used_q <= used_d;
    end
  end

  assign canSend = used_q < limit;

  a_credit_one: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!paramDone && used_q != '0) |-> !canSend)
    else $error("More than one frame outstanding before parameter exchange.");

  a_credit_back: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (readyRcvd && !frameSent && used_q != '0) |=> used_q == $past(used_q) - CW'(1))
    else $error("Returned ready did not free a credit.");

endmodule

// ### ips_steer.sv
`timescale 1ns/1ps
// Inter-switch port frame steering, primitive filter and principal link routing.
// How it works
// - Primitive sequences and signals other than idle never enter the construct.
// - Switch-side port carries class F and routes class 2 and/or 3.
// - Bridge-side port carries class F and forwards class 2 and/or 3.
// - Switch-side inbound frames go to construct or link control at FFFFFDh.
// - Switch-side outbound frames go to transmitter or internal control facility.
// - Internal control accepts internal link service requests, answers each one.
// - Bridge-side inbound frames go to bridge construct or link control facility.
// - Bridge-side outbound frames go to transmitter or internal control facility.
// - A link joins one switch port to one switch or bridge port.
// - Point-to-point framing kept, but class F frames cross the link.
// - Class F credit uses ready primitives until parameters are exchanged.
// - Losing the principal link triggers a build-fabric request; raised only when BRIDGE_SIDE is 0.
// - Losing a non-principal link needs only a routing change.
// - Frames for the principal switch leave on the upstream principal link.
// - Principal switch has no upstream link; others exactly one.
// - Replies to upstream frames leave on the downstream link toward target.
// - Class F chosen per frame; consecutive frames demultiplexed by destination.
// - Class F frames carry class F delimiters.
// - Class F otherwise behaves like class 2.
// - Undeliverable class F frames cause a non-delivery notice to sender.
// - Credit of one assumed before parameter exchange.
// - Class F data field at most 256 bytes before exchange.
// - Zero-variant acknowledgement never sent for class F.
module ips_steer
  import ips_pkg::*;
#(
  parameter bit BRIDGE_SIDE = 1'b0,
  parameter bit HAS_CLASS2 = 1'b1,
  parameter bit HAS_CLASS3 = 1'b1,
  parameter int DW = 32,
  parameter int CW = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Receive side from the link decoder.
  input wire logic rxValid,
  input wire ips_word_e rxKind,
  input wire logic [1:0] rxClass,
  input wire logic [DW-1:0] rxData,
  // Inbound frame words toward the construct.
  output logic mainValid,
  output logic [DW-1:0] mainData,
  output logic mainSof,
  output logic mainEof,
  output logic [1:0] mainClass,
  // Inbound frame words toward the link control facility.
  output logic lcfValid,
  output logic [DW-1:0] lcfData,
  output logic lcfSof,
  output logic lcfEof,
  // Receive error and non-delivery notice.
  output logic rxDrop,
  output logic nonDeliver,
  // Outbound frames from the construct.
  input wire logic outValid,
  input wire logic outSof,
  input wire logic outEof,
  input wire logic [1:0] outClass,
  input wire logic outToCtrl,
  input wire logic outIsAck0,
  input wire logic [DW-1:0] outData,
  output logic outReady,
  // Toward the link transmitter.
  output logic txValid,
  output logic txSof,
  output logic txEof,
  output logic [1:0] txClass,
  output logic [DW-1:0] txData,
  input wire logic txReadyRcvd,
  // Toward the internal control facility.
  output logic icfValid,
  output logic [DW-1:0] icfData,
  output logic icfSof,
  output logic icfEof,
  // Link state and principal links.
  input wire logic paramDone,
  input wire logic [CW-1:0] agreedCredit,
  input wire logic linkUp,
  input wire logic isPrincipal,
  input wire logic principalSwitch,
  input wire logic isUpstream,
  output logic buildFabric,
  output logic routeChange,
  output logic principalFault
);

  typedef enum {RX_IDLE, RX_HEAD, RX_BODY} ips_rx_e;

  ips_rx_e rxSt_q, rxSt_d;
  ips_dst_e dst_q, dst_d;
  logic [9:0] cnt_q, cnt_d;
  logic [1:0] cls_q, cls_d;
  logic classOk, isFrameWord, tooLong;
  logic [23:0] did;

  // The destination sits in the low 24 bits of the first header word.
  assign did = rxData[23:0];
  // Class F always; class 2 and 3 per build option.
  assign classOk = (rxClass == IPS_CLS_F)
                   || (rxClass == IPS_CLS_2 && HAS_CLASS2)
                   || (rxClass == IPS_CLS_3 && HAS_CLASS3);
  // Only frame words pass the filter; primitives and idles are dropped here.
  assign isFrameWord = rxValid && (rxKind == IPS_W_SOF || rxKind == IPS_W_DATA
                       || rxKind == IPS_W_EOF);
  assign tooLong = !paramDone && cls_q == IPS_CLS_F
                   && cnt_q >= IPS_HDR_WORDS + IPS_PRE_ELP_WORDS;

  // Receive steering: the start word is never passed on and steering waits for the destination word,
  // so no word goes anywhere before the frame's destination is known.
  always_comb begin
    rxSt_d = rxSt_q;
    dst_d = dst_q;
    cnt_d = cnt_q;
    cls_d = cls_q;
    mainValid = 1'b0;
    lcfValid = 1'b0;
    mainSof = 1'b0;
    lcfSof = 1'b0;
    mainEof = 1'b0;
    lcfEof = 1'b0;
    rxDrop = 1'b0;
    case (rxSt_q)
      RX_IDLE: begin
        if (isFrameWord && rxKind == IPS_W_SOF) begin
          if (classOk) begin
            rxSt_d = RX_HEAD;
            cls_d = rxClass;
          end else begin
            rxDrop = 1'b1;
          end
        end
      end
      RX_HEAD: begin
        if (isFrameWord && rxKind == IPS_W_DATA) begin
          // Link control facility address for both port forms.
          dst_d = (did == IPS_LCF_ADDR) ? IPS_DST_CTRL : IPS_DST_MAIN;
          rxSt_d = RX_BODY;
          cnt_d = 10'h001;
        end else if (isFrameWord) begin
          rxSt_d = RX_IDLE;
          rxDrop = 1'b1;
        end
      end
      RX_BODY: begin
        if (isFrameWord) begin
          mainValid = (dst_q == IPS_DST_MAIN);
          lcfValid = (dst_q == IPS_DST_CTRL);
          mainSof = mainValid && cnt_q == 10'h001;
          lcfSof = lcfValid && cnt_q == 10'h001;
          cnt_d = cnt_q + 10'h001;
          if (rxKind == IPS_W_EOF) begin
            mainEof = mainValid;
            lcfEof = lcfValid;
            rxSt_d = RX_IDLE;
            dst_d = IPS_DST_NONE;
          end else if (rxKind == IPS_W_SOF || tooLong) begin
            mainEof = mainValid;
            lcfEof = lcfValid;
            rxDrop = 1'b1;
            rxSt_d = RX_IDLE;
            dst_d = IPS_DST_NONE;
          end
        end
      end
      default: begin
        rxSt_d = RX_IDLE;
      end
    endcase
  end

  // Receive state registers.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxSt_q <= RX_IDLE;
      dst_q <= IPS_DST_NONE;
      cnt_q <= 10'h000;
      cls_q <= IPS_CLS_F;
    end else begin
      rxSt_q <= rxSt_d;
      dst_q <= dst_d;
      cnt_q <= cnt_d;
      cls_q <= cls_d;
    end
  end

  // Data words are registered copies of the received word, one frame word behind the strobe,
  // so the first steered word is the held destination word.
  logic [DW-1:0] mainData_q, lcfData_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mainData_q <= '0;
      lcfData_q <= '0;
    end else if (rxSt_q == RX_HEAD) begin
      mainData_q <= rxData;
      lcfData_q <= rxData;
    end else if (isFrameWord) begin
      mainData_q <= rxData;
      lcfData_q <= rxData;
    end
  end
  // Class travels with the steered frame so the construct treats F like class 2.
  assign mainData = mainData_q;
  assign lcfData = lcfData_q;
  assign mainClass = cls_q;

  // Transmit side: credit check before a frame starts.
  logic canSend, frameSent;
  logic txBusy_q, txBusy_d, toCtrl_q, toCtrl_d;
  logic ackDrop_q, ackDrop_d;
  logic goCtrl, startOk, ack0Block, fwdPrincipal, toIcf;

  ips_credit #(.CW(CW)) uCredit (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .paramDone(paramDone),
    .agreedCredit(agreedCredit),
    .frameSent(frameSent),
    .readyRcvd(txReadyRcvd),
    .canSend(canSend)
  );

  // Traffic on an upstream principal port is sent unless this is the principal switch; a
  // principal switch cannot own an upstream link so such traffic is refused.
  assign fwdPrincipal = !(principalSwitch && isPrincipal && isUpstream);
  assign goCtrl = outToCtrl;
  assign ack0Block = outIsAck0 && outClass == IPS_CLS_F;
  assign startOk = goCtrl || (canSend && linkUp && fwdPrincipal);

  always_comb begin
    txBusy_d = txBusy_q;
    toCtrl_d = toCtrl_q;
    ackDrop_d = ackDrop_q;
    outReady = 1'b0;
    frameSent = 1'b0;
    if (outValid && outSof && !txBusy_q && !ackDrop_q) begin
      outReady = startOk || ack0Block;
      if (ack0Block) begin
        // The rest of a refused acknowledgement is swallowed so the sender never hangs.
        ackDrop_d = !outEof;
      end else if (startOk) begin
        toCtrl_d = goCtrl;
        txBusy_d = !outEof;
        frameSent = !goCtrl;
      end
    end else if (outValid && (txBusy_q || ackDrop_q)) begin
      outReady = 1'b1;
      if (outEof) begin
        txBusy_d = 1'b0;
        ackDrop_d = 1'b0;
      end
    end
  end

  // Transmit registers; data outputs come from flip-flops.
  logic fire;
  assign fire = outValid && outReady && !(outSof && ack0Block) && !ackDrop_q;
  // Frame markers follow the word to the side that carries it.
  assign toIcf = outSof ? goCtrl : toCtrl_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      txBusy_q <= 1'b0;
      toCtrl_q <= 1'b0;
      ackDrop_q <= 1'b0;
      txValid <= 1'b0;
      icfValid <= 1'b0;
      txSof <= 1'b0;
      txEof <= 1'b0;
      icfSof <= 1'b0;
      icfEof <= 1'b0;
      txClass <= IPS_CLS_F;
      txData <= '0;
      icfData <= '0;
    end else begin
      txBusy_q <= txBusy_d;
      toCtrl_q <= toCtrl_d;
      ackDrop_q <= ackDrop_d;
      txValid <= fire && !toIcf;
      icfValid <= fire && toIcf;
      txSof <= fire && outSof && !toIcf;
      txEof <= fire && outEof && !toIcf;
      icfSof <= fire && outSof && toIcf;
      icfEof <= fire && outEof && toIcf;
      txClass <= outClass;
      txData <= outData;
      icfData <= outData;
    end
  end

  // Link loss handling: principal loss rebuilds on the switch side only, other loss reroutes.
  logic linkUp_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      linkUp_q <= 1'b0;
      buildFabric <= 1'b0;
      routeChange <= 1'b0;
      nonDeliver <= 1'b0;
      principalFault <= 1'b0;
    end else begin
      linkUp_q <= linkUp;
      buildFabric <= linkUp_q && !linkUp && isPrincipal && !BRIDGE_SIDE;
      routeChange <= linkUp_q && !linkUp && !isPrincipal;
      // Refused class F frames at start tell the sender through this flag, high each cycle the start word waits.
      nonDeliver <= outValid && outSof && !txBusy_q && !goCtrl && outClass == IPS_CLS_F
                    && (!linkUp || !fwdPrincipal);
      principalFault <= principalSwitch && isPrincipal && isUpstream;
    end
  end

  a_no_prim_pass: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rxValid && (rxKind == IPS_W_PSIG || rxKind == IPS_W_PSEQ || rxKind == IPS_W_IDLE))
    |-> !mainValid && !lcfValid)
    else $error("Primitive passed toward construct.");

  a_lcf_steer: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rxSt_q == RX_HEAD && isFrameWord && rxKind == IPS_W_DATA && did == IPS_LCF_ADDR)
    |=> dst_q == IPS_DST_CTRL)
    else $error("Control address not steered to link control.");

  a_head_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rxSt_q != RX_BODY) |-> !mainValid && !lcfValid)
    else $error("Word passed before steering decided.");

  a_pf_build: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ($fell(linkUp) && isPrincipal && !BRIDGE_SIDE) |=> buildFabric)
    else $error("Principal link loss did not rebuild.");

  a_ack0_never: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (outValid && outSof && ack0Block && !txBusy_q) |=> !txValid && !icfValid)
    else $error("Zero acknowledgement sent for class F.");

  a_len_limit: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (tooLong && isFrameWord && rxSt_q == RX_BODY) |=> rxSt_q == RX_IDLE)
    else $error("Oversized class F frame not cut.");

  a_tx_marks: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (txSof || txEof) |-> txValid && !icfValid)
    else $error("Transmit frame marker without a transmit word.");

  a_icf_marks: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (icfSof || icfEof) |-> icfValid && !txValid)
    else $error("Control frame marker without a control word.");

endmodule

// ### ips_peer.sv
// Peer port model at the far end of the link: sends words and returns ready primitives.
`timescale 1ns/1ps
module ips_peer
  import ips_pkg::*;
(
  input wire logic ref_clk,
  input wire logic txValid,
  input wire logic txEof,
  output logic rxValid,
  output ips_word_e rxKind,
  output logic [1:0] rxClass,
  output logic [31:0] rxData,
  output logic txReadyRcvd
);
  int gap = 2;
  int waitQ = -1;
  int owed = 0;
  int due;

  // Quiet link at start; the model is the single peer on this link.
  initial begin
    rxValid = 1'b0;
    rxKind = IPS_W_IDLE;
    rxClass = 2'h0;
    rxData = 32'h0;
    txReadyRcvd = 1'b0;
  end

  // One buffer is freed per received frame after gap cycles; frames that end while a
  // timer runs are owed and answered in turn, so no ready is ever lost.
  always @(posedge ref_clk) begin
    txReadyRcvd <= (waitQ == 0);
    due = owed + int'(txValid && txEof);
    if (waitQ > 0) begin
      waitQ <= waitQ - 1;
      owed <= due;
    end else if (due > 0) begin
      waitQ <= gap;
      owed <= due - 1;
    end else begin
      waitQ <= -1;
    end
  end

  // One word per cycle, changed just after the edge.
  task automatic word(input ips_word_e k, input logic [1:0] c, input logic [31:0] d);
    @(posedge ref_clk);
    rxValid <= 1'b1;
    rxKind <= k;
    rxClass <= c;
    rxData <= d;
  endtask

  // The data line shows the inverse of the last word once released, never a held value.
  task automatic idle();
    @(posedge ref_clk);
    rxValid <= 1'b0;
    rxData <= ~rxData;
  endtask

  // Start word carries the class, then the destination word, data and the end word.
  task automatic frame(input logic [1:0] c, input logic [23:0] did, input int n);
    word(IPS_W_SOF, c, 32'h0);
    word(IPS_W_DATA, c, {8'h0, did});
    for (int i = 0; i < n; i++)
      word(IPS_W_DATA, c, 32'h100 + i);
    word(IPS_W_EOF, c, 32'h0);
    idle();
  endtask
endmodule

// ### test_isl_port_frame_steering.sv
// Self-checking bench for the inter-switch port steering block.
`timescale 1ns/1ps
module test_isl_port_frame_steering
  import ips_pkg::*;
();
  localparam int CM = 0, CL = 1, CE = 2, CD = 3, CT = 4, CI = 5, CB = 6, CR = 7;
  localparam int CS = 8, CF = 9, CN = 10;
  logic [31:0] txHead;
  logic [1:0] txHeadCls;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rxValid, mainValid, mainSof, mainEof, lcfValid, lcfSof, lcfEof, rxDrop, nonDeliver;
  ips_word_e rxKind;
  logic [1:0] rxClass, mainClass, outClass, txClass, firstCls;
  logic [31:0] rxData, mainData, lcfData, outData, txData, icfData, firstData;
  logic outValid, outSof, outEof, outToCtrl, outIsAck0, outReady, txValid, txSof, txEof;
  logic txReadyRcvd, icfValid, icfSof, icfEof, paramDone, linkUp, isPrincipal;
  logic principalSwitch, isUpstream, buildFabric, routeChange, principalFault;
  logic [7:0] agreedCredit;
  int errors = 0;
  int checked = 0;
  int cnt [11];

  always #12.5 ref_clk = ~ref_clk;

  ips_steer dut (
    .ref_clk, .sys_rst, .rxValid, .rxKind, .rxClass, .rxData, .mainValid, .mainData,
    .mainSof, .mainEof, .mainClass, .lcfValid, .lcfData, .lcfSof, .lcfEof, .rxDrop,
    .nonDeliver, .outValid, .outSof, .outEof, .outClass, .outToCtrl, .outIsAck0, .outData,
    .outReady, .txValid, .txSof, .txEof, .txClass, .txData, .txReadyRcvd, .icfValid,
    .icfData, .icfSof, .icfEof, .paramDone, .agreedCredit, .linkUp, .isPrincipal,
    .principalSwitch, .isUpstream, .buildFabric, .routeChange, .principalFault
  );

  ips_peer peer (
    .ref_clk, .txValid, .txEof, .rxValid, .rxKind, .rxClass, .rxData, .txReadyRcvd
  );

  // Receive strobes are combinational, so all strobes are tallied mid-cycle once settled.
  always @(negedge ref_clk) begin
    if (mainValid) cnt[CM]++;
    if (mainValid && mainSof) firstData = mainData;
    if (mainValid && mainSof) firstCls = mainClass;
    if ((mainValid && mainEof) || (lcfValid && lcfEof)) cnt[CE]++;
    if (lcfValid) cnt[CL]++;
    if (rxDrop) cnt[CD]++;
    if (txValid) cnt[CT]++;
    if (icfValid) cnt[CI]++;
    if (buildFabric) cnt[CB]++;
    if (routeChange) cnt[CR]++;
    if (txValid && txSof && cnt[CS] == 0) txHead = txData;
    if (txValid && txSof && cnt[CS] == 0) txHeadCls = txClass;
    if (txValid && txSof) cnt[CS]++;
    if (icfValid && icfSof) cnt[CF]++;
    if (nonDeliver) cnt[CN]++;
  end

  task automatic cmp_n(input string what, input int exp, input int got);
    checked++;
    if (exp != got) begin
      errors++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic cmp_v(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hold each outbound word until taken; g returns the cycles spent waiting.
  task automatic put(input logic s, e, k, a, input logic [1:0] c, input logic [31:0] d,
                     output int g);
    g = 0;
    outValid <= 1'b1;
    outSof <= s;
    outEof <= e;
    outToCtrl <= k;
    outIsAck0 <= a;
    outClass <= c;
    outData <= d;
    @(negedge ref_clk);
    while (!outReady && g < 300) begin
      @(negedge ref_clk);
      g++;
    end
    if (g >= 300) cmp_n("word taken", 1, 0);
    @(posedge ref_clk);
  endtask

  // An edge passes first so valid is never lowered and raised in one step.
  task automatic sendf(input logic [1:0] c, input logic k, a, input int n, output int w);
    int g;
    w = 0;
    @(posedge ref_clk);
    for (int i = 0; i <= n; i++) begin
      put(i == 0, i == n, k, a, c, 32'h200 + i, g);
      w += g;
    end
    outValid <= 1'b0;
  endtask

  // Primitives of every kind must leave no trace on the construct side.
  task automatic t_prims();
    cnt = '{default: 0};
    peer.word(IPS_W_IDLE, 2'h0, 32'h0);
    peer.word(IPS_W_PSIG, 2'h0, 32'hf0f0);
    peer.word(IPS_W_PSEQ, 2'h0, 32'h0f0f);
    peer.idle();
    repeat (3) @(posedge ref_clk);
    cmp_n("prim words", 0, cnt[CM] + cnt[CL]);
  endtask

  // Steering by destination; the first steered word is the destination word.
  task automatic t_steer(input logic [1:0] c, input logic [23:0] did, input int n);
    int lcf;
    lcf = int'(did == IPS_LCF_ADDR);
    cnt = '{default: 0};
    peer.frame(c, did, n);
    repeat (3) @(posedge ref_clk);
    cmp_n("main words", lcf ? 0 : n + 1, cnt[CM]);
    cmp_n("lcf words", lcf ? n + 1 : 0, cnt[CL]);
    cmp_n("frame ends", 1, cnt[CE]);
    if (lcf == 0) cmp_v("first word", {8'h0, did}, firstData);
    if (lcf == 0) cmp_v("frame class", c, firstCls);
  endtask

  // A start word with an unknown class is refused.
  task automatic t_bad();
    cnt = '{default: 0};
    peer.frame(2'h1, 24'h010203, 2);
    repeat (3) @(posedge ref_clk);
    cmp_n("bad class drop", 1, int'(cnt[CD] > 0));
    cmp_n("bad class words", 0, cnt[CM] + cnt[CL]);
  endtask

  // Long class F frames are cut only before the parameter exchange.
  task automatic t_size(input int n);
    cnt = '{default: 0};
    peer.frame(IPS_CLS_F, 24'h020000, n);
    repeat (3) @(posedge ref_clk);
    cmp_n("long cut", int'(!paramDone && n + 1 > IPS_HDR_WORDS + IPS_PRE_ELP_WORDS),
          int'(cnt[CD] > 0));
  endtask

  // A slow peer stalls the next frame; control and zero-variant frames stay off the link.
  task automatic t_out();
    int w;
    cnt = '{default: 0};
    peer.gap = 20;
    sendf(IPS_CLS_F, 1'b0, 1'b0, 2, w);
    sendf(IPS_CLS_2, 1'b0, 1'b0, 1, w);
    cmp_n("credit stall", 1, int'(w >= 15));
    sendf(IPS_CLS_3, 1'b1, 1'b0, 3, w);
    sendf(IPS_CLS_F, 1'b0, 1'b1, 1, w);
    repeat (30) @(posedge ref_clk);
    cmp_n("tx words", 5, cnt[CT]);
    cmp_n("ctrl words", 4, cnt[CI]);
    cmp_n("tx starts", 2, cnt[CS]);
    cmp_n("ctrl starts", 1, cnt[CF]);
    cmp_v("tx head", 32'h200, txHead);
    cmp_v("tx class", IPS_CLS_F, txHeadCls);
  endtask

  // After the exchange the agreed credit of two lets two frames pass unstalled.
  task automatic t_elp();
    int w1, w2;
    paramDone <= 1'b1;
    agreedCredit <= 8'h02;
    t_size(70);
    sendf(IPS_CLS_2, 1'b0, 1'b0, 1, w1);
    sendf(IPS_CLS_2, 1'b0, 1'b0, 1, w2);
    cmp_n("agreed credit", 1, int'(w1 + w2 < 3));
  endtask

  // Losing the principal link asks for a rebuild; another link only reroutes.
  task automatic t_loss(input logic p);
    cnt = '{default: 0};
    isPrincipal <= p;
    @(posedge ref_clk);
    linkUp <= 1'b0;
    outValid <= 1'b1;
    outSof <= 1'b1;
    outToCtrl <= 1'b0;
    outIsAck0 <= 1'b0;
    outClass <= IPS_CLS_F;
    repeat (4) @(posedge ref_clk);
    outValid <= 1'b0;
    cmp_n("non delivery", 1, int'(cnt[CN] > 0));
    cmp_n("build fabric", int'(p), cnt[CB]);
    if (!p) cmp_n("route change", 1, cnt[CR]);
    linkUp <= 1'b1;
    principalSwitch <= p;
    isUpstream <= p;
    repeat (3) @(posedge ref_clk);
    cmp_v("principal fault", p, principalFault);
    principalSwitch <= 1'b0;
    isUpstream <= 1'b0;
  endtask

  // Timeout: the run needs a few hundred cycles, so a hang is cut well after that, at 20000 cycles.
  initial begin
    #(25 * 20000);
    errors++;
    close_out();
  end

  initial begin
    {outValid, outSof, outEof, outToCtrl, outIsAck0, paramDone, linkUp} = '0;
    {isPrincipal, principalSwitch, isUpstream} = '0;
    outClass = 2'h0;
    outData = 32'h0;
    agreedCredit = 8'h00;
    cnt = '{default: 0};
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    linkUp <= 1'b1;
    t_prims();
    t_steer(IPS_CLS_2, 24'h010203, 3);
    t_steer(IPS_CLS_3, 24'hfffffc, 1);
    t_steer(IPS_CLS_F, 24'hfffffd, 2);
    t_steer(IPS_CLS_F, 24'hfffffe, 2);
    t_bad();
    t_size(69);
    t_size(70);
    t_out();
    t_elp();
    t_loss(1'b1);
    t_loss(1'b0);
    close_out();
  end
endmodule
